/* inc/sbsp_regs.vh */
// Constants for the buffered serial port: control bit positions and sizes
// Overview of operation
// - Standard single buffer or eight-entry FIFO mode
// - Framed protocol, master or slave, four configurations; only a master generates the frame pulse
// - Four pins: data in, out, clock, select
// - Configurable for four, three or two pins
// - Master starts shifting once data buffer written; when framed with frm_slave set it also waits for the frame pulse
// - Control one bit 5 selects master role
// - Status bit 15 enables port, set last
// - Control two bit 0 selects FIFO mode
// - Exactly one serial port instance exists
// - Word-width bit picks 16 or 8 bits
// - Unread data: discard new word, set overflow
// - Primary prescale codes 1, 4, 16, 64
// - Transmit-full sets on write, clears on load
`ifndef SBSP_REGS_VH
`define SBSP_REGS_VH

// ----------------------------------------
// Control register one bit positions
// ----------------------------------------
`define SBSP_C1_PRIMARY_PRESCALE_LO 0
`define SBSP_C1_SECONDARY_PRESCALE_LO 2
`define SBSP_C1_MASTER 5
`define SBSP_C1_CKP 6
`define SBSP_C1_SELECT_LINE_ENABLE 7
`define SBSP_C1_CKE 8
`define SBSP_C1_SMP 9
`define SBSP_C1_WIDE 10
`define SBSP_C1_DIS_SDO 11
`define SBSP_C1_DIS_SCK 12

// ----------------------------------------
// Control register two and status bit positions
// ----------------------------------------
`define SBSP_C2_FIFO 0
`define SBSP_C2_FRAME 15
`define SBSP_C2_FRM_SLAVE 14
`define SBSP_ST_ENABLE 15
`define SBSP_ST_ROV 6

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define SBSP_FIFO_DEPTH 8
`define SBSP_FIFO_AW 3
`define SBSP_DATA_W 16
`define SBSP_RESET_WORD 16'h0000

`endif

/* hdl/sbsp_fifo.v */
// Parameterised valid/ready FIFO for the serial port data paths
`timescale 1ns/1ps
module sbsp_fifo #(
  parameter W = 16,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Flush
  input wire flush,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  // Fill level
  output wire [AW:0] count
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire wr = in_valid && in_ready;
  wire rd = out_valid && out_ready;
  localparam [AW:0] FULL_N = D;
  localparam [AW:0] LAST_I = D - 1;

  assign in_ready = (cnt_q != FULL_N);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  assign count = cnt_q;

  always @(posedge clk) begin
    if (wr) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= (wp_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

/* hdl/sbsp_top.v */
// Buffered serial port: master/slave shifter with single or FIFO buffering
`timescale 1ns/1ps
`include "sbsp_regs.vh"
// One port per device; nothing here is shared or indexed
module sbsp_top (
  // Clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // Configuration words
  input wire [15:0] CONTROL_REG_ONE,
  input wire [15:0] CONTROL_REG_TWO,
  input wire PORT_ENABLE,
  // Data buffer write side
  input wire TX_WRITE,
  input wire [15:0] TX_DATA,
  output wire TX_READY,
  // Data buffer read side
  input wire RX_READ,
  output wire [15:0] RX_DATA,
  output wire RX_VALID,
  // Status
  input wire OVERFLOW_CLEAR,
  output wire RECEIVE_OVERFLOW_FLAG,
  output wire TX_BUFFER_FULL_FLAG,
  output wire SHIFT_REG_EMPTY,
  output wire RX_FIFO_EMPTY,
  output wire [2:0] TX_PENDING_COUNT,
  output wire [2:0] RX_UNREAD_COUNT,
  output wire TRANSFER_DONE,
  // Serial pins
  input wire SERIAL_DATA_IN,
  output wire SERIAL_DATA_OUT,
  output wire SERIAL_DATA_OUT_OE,
  input wire SHIFT_CLOCK_IN,
  output wire SHIFT_CLOCK_OUT,
  output wire SHIFT_CLOCK_OE,
  input wire SELECT_N_OR_FRAME_PULSE_IN,
  output wire SELECT_N_OR_FRAME_PULSE_OUT,
  output wire SELECT_N_OR_FRAME_PULSE_OE
);
  // ----------------------------------------
  // States and helpers
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_FRAME = 3'b010;
  localparam ST_SHIFT = 3'b100;

  // Primary prescale ratio as a divide count
  function [6:0] pri_ratio;
    input [1:0] code;
    begin
      case (code)
        2'b11: pri_ratio = 7'h01;
        2'b10: pri_ratio = 7'h04;
        2'b01: pri_ratio = 7'h10;
        default: pri_ratio = 7'h40;
      endcase
    end
  endfunction

  // Top bit of the active word width
  function msb_of;
    input [15:0] word;
    input is_wide;
    begin
      msb_of = is_wide ? word[15] : word[7];
    end
  endfunction

  wire [15:0] c1 = CONTROL_REG_ONE;
  wire [15:0] c2 = CONTROL_REG_TWO;
  wire en = PORT_ENABLE;
  wire master = c1[`SBSP_C1_MASTER];
  wire fifo_mode = c2[`SBSP_C2_FIFO];
  wire wide = c1[`SBSP_C1_WIDE];
  wire ckp = c1[`SBSP_C1_CKP];
  wire cke = c1[`SBSP_C1_CKE];
  wire input_sample_phase = c1[`SBSP_C1_SMP];
  wire select_line_enable = c1[`SBSP_C1_SELECT_LINE_ENABLE];
  wire framed = c2[`SBSP_C2_FRAME];
  wire frm_slave = c2[`SBSP_C2_FRM_SLAVE];
  wire [4:0] nbits = wide ? 5'h10 : 5'h08;
  // Overall clock divide: primary times secondary (secondary 1..8)
  wire [3:0] sec = 4'h8 - {1'b0, c1[`SBSP_C1_SECONDARY_PRESCALE_LO +: 3]};
  wire [9:0] div_full = pri_ratio(c1[1:0]) * sec;

  // ----------------------------------------
  // Transmit and receive buffers
  // ----------------------------------------
  // Standard mode caps both FIFOs at one entry so the single-buffer
  // flags behave as documented without a second datapath.
  wire [3:0] tx_cnt;
  wire [3:0] rx_cnt;
  wire cap_tx = !fifo_mode && (tx_cnt != 4'h0);
  wire cap_rx = !fifo_mode && (rx_cnt != 4'h0);
  wire tx_in_ready;
  wire rx_in_ready;
  wire rx_room = rx_in_ready && !cap_rx;
  wire tx_avail;
  wire [15:0] tx_word;
  reg tx_pop;
  reg rx_push;
  reg [15:0] rx_word_q;

  sbsp_fifo #(
    .W(`SBSP_DATA_W),
    .D(`SBSP_FIFO_DEPTH),
    .AW(`SBSP_FIFO_AW)
  ) u_txf (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .flush(!en),
    .in_valid(TX_WRITE && TX_READY),
    .in_ready(tx_in_ready),
    .in_data(TX_DATA),
    .out_valid(tx_avail),
    .out_ready(tx_pop),
    .out_data(tx_word),
    .count(tx_cnt)
  );

  sbsp_fifo #(
    .W(`SBSP_DATA_W),
    .D(`SBSP_FIFO_DEPTH),
    .AW(`SBSP_FIFO_AW)
  ) u_rxf (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .flush(!en),
    .in_valid(rx_push && rx_room),
    .in_ready(rx_in_ready),
    .in_data(rx_word_q),
    .out_valid(RX_VALID),
    .out_ready(RX_READ),
    .out_data(RX_DATA),
    .count(rx_cnt)
  );

  assign TX_READY = en && tx_in_ready && !cap_tx;
  assign TX_BUFFER_FULL_FLAG = !TX_READY && en;
  assign RX_FIFO_EMPTY = !RX_VALID;
  assign TX_PENDING_COUNT = tx_cnt[2:0];
  assign RX_UNREAD_COUNT = rx_cnt[2:0];

  // ----------------------------------------
  // Slave-side pin edge detection
  // ----------------------------------------
  reg sck_q;
  reg ss_q;
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_q <= 1'b0;
      ss_q <= 1'b1;
    end else begin
      sck_q <= SHIFT_CLOCK_IN;
      ss_q <= SELECT_N_OR_FRAME_PULSE_IN;
    end
  end
  // Leading edge leaves idle level; trailing edge returns to it
  wire sck_act = SHIFT_CLOCK_IN ^ ckp;
  wire sck_act_q = sck_q ^ ckp;
  wire s_lead = sck_act && !sck_act_q;
  wire s_trail = !sck_act && sck_act_q;
  wire ss_fall = ss_q && !SELECT_N_OR_FRAME_PULSE_IN;
  wire sel_ok = !select_line_enable || !SELECT_N_OR_FRAME_PULSE_IN;

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  reg [2:0] st_q;
  reg [15:0] sh_q;
  reg [4:0] bit_q;
  reg [9:0] div_q;
  reg sclk_q;
  reg sdo_q;
  reg frm_q;
  reg rov_q;
  reg done_q;
  reg first_q;

  // Master tick: half period of the shift clock
  wire m_tick = (div_q == 10'h000);
  wire [9:0] half = (div_full > 10'h001) ? (div_full >> 1) - 10'h001
                                         : 10'h000;
  // Master: change/sample on internal shift-clock half edges
  wire lead_e = master ? (m_tick && !sclk_q) : s_lead;
  wire trail_e = master ? (m_tick && sclk_q) : s_trail;
  wire chg_e = cke ? trail_e : lead_e;
  wire smp_e = (master && input_sample_phase) ? (cke ? lead_e : trail_e)
                               : (cke ? lead_e : trail_e);
  wire last_bit = (bit_q == 5'h01);
  wire sdo_bit = msb_of(sh_q, wide);

  always @* begin
    tx_pop = 1'b0;
    if (en && st_q == ST_IDLE && tx_avail) begin
      if (master) begin
        tx_pop = !framed || !frm_slave || ss_fall;
      end else begin
        tx_pop = framed ? ss_fall : (sel_ok && s_lead);
      end
    end
  end

  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_IDLE;
      sh_q <= `SBSP_RESET_WORD;
      bit_q <= 5'h00;
      div_q <= 10'h000;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
      frm_q <= 1'b0;
      rov_q <= 1'b0;
      done_q <= 1'b0;
      first_q <= 1'b0;
      rx_push <= 1'b0;
      rx_word_q <= `SBSP_RESET_WORD;
    end else begin
      rx_push <= 1'b0;
      done_q <= 1'b0;
      div_q <= m_tick ? half : div_q - 10'h001;
      // Set wins over a clear in the same cycle
      if (rx_push && !rx_room) begin
        rov_q <= 1'b1;
      end else if (OVERFLOW_CLEAR) begin
        rov_q <= 1'b0;
      end
      if (!en) begin
        st_q <= ST_IDLE;
        sclk_q <= 1'b0;
        frm_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            sclk_q <= 1'b0;
            // Unframed slave sends zeros when nothing queued yet still receives
            if (tx_pop || (!master && !framed && sel_ok && s_lead)) begin
              sh_q <= tx_pop ? tx_word : 16'h0000;
              bit_q <= nbits;
              // A slave's starting edge already is its first leading edge
              first_q <= !cke && master;
              div_q <= half;
              frm_q <= master && framed && !frm_slave;
              st_q <= (master && framed && !frm_slave) ? ST_FRAME
                                                       : ST_SHIFT;
              sdo_q <= tx_pop ? msb_of(tx_word, wide) : 1'b0;
            end
          end
          ST_FRAME: begin
            // One shift-clock period of frame pulse before data
            if (m_tick && sclk_q) begin
              frm_q <= 1'b0;
              st_q <= ST_SHIFT;
            end
            if (m_tick) begin
              sclk_q <= !sclk_q;
            end
          end
          ST_SHIFT: begin
            if (master && m_tick) begin
              sclk_q <= !sclk_q;
            end
            if (!master && select_line_enable && !framed &&
                SELECT_N_OR_FRAME_PULSE_IN) begin
              st_q <= ST_IDLE; // select lost aborts the word
            end else begin
              if (chg_e && !first_q) begin
                sdo_q <= sdo_bit;
              end
              if (chg_e) begin
                first_q <= 1'b0;
              end
              if (smp_e) begin
                sh_q <= {sh_q[14:0], SERIAL_DATA_IN};
                bit_q <= bit_q - 5'h01;
                if (last_bit) begin
                  rx_word_q <= wide ? {sh_q[14:0], SERIAL_DATA_IN}
                                    : {8'h00, sh_q[6:0], SERIAL_DATA_IN};
                  rx_push <= 1'b1;
                  done_q <= 1'b1;
                  st_q <= ST_IDLE;
                end
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign SHIFT_REG_EMPTY = (st_q == ST_IDLE);
  assign RECEIVE_OVERFLOW_FLAG = rov_q;
  assign TRANSFER_DONE = done_q;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // disable bits drop clock or data out; select is driven only when framed with frm_slave clear
  assign SERIAL_DATA_OUT = sdo_q;
  assign SERIAL_DATA_OUT_OE = en && !c1[`SBSP_C1_DIS_SDO];
  assign SHIFT_CLOCK_OUT = sclk_q ^ ckp;
  assign SHIFT_CLOCK_OE = en && master && !c1[`SBSP_C1_DIS_SCK];
  assign SELECT_N_OR_FRAME_PULSE_OUT = framed ? frm_q : 1'b1;
  assign SELECT_N_OR_FRAME_PULSE_OE = en && framed && !frm_slave;
endmodule

/* sim/sbsp_chk.sv */
// Concurrent checks on the serial port top-level pins
`timescale 1ns/1ps
module sbsp_chk (
  // Clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // Watched pins
  input wire [15:0] CONTROL_REG_ONE,
  input wire [15:0] CONTROL_REG_TWO,
  input wire PORT_ENABLE,
  input wire TX_WRITE,
  input wire TX_READY,
  input wire RX_VALID,
  input wire OVERFLOW_CLEAR,
  input wire RECEIVE_OVERFLOW_FLAG,
  input wire TX_BUFFER_FULL_FLAG,
  input wire SHIFT_REG_EMPTY,
  input wire TRANSFER_DONE,
  input wire SERIAL_DATA_OUT_OE,
  input wire SHIFT_CLOCK_OE
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  full_flag_a: assert property (
    TX_BUFFER_FULL_FLAG == (PORT_ENABLE && !TX_READY)) else $error("bad full");
  start_shift_a: assert property (
    PORT_ENABLE && CONTROL_REG_ONE[5] && !CONTROL_REG_TWO[14] &&
    TX_WRITE && TX_READY && SHIFT_REG_EMPTY ##1 PORT_ENABLE
    |=> !SHIFT_REG_EMPTY) else $error("no start");
  done_pulse_a: assert property (
    TRANSFER_DONE |=> !TRANSFER_DONE) else $error("done too long");
  rx_after_done_a: assert property (
    TRANSFER_DONE |=> RX_VALID) else $error("no rx word");
  ovf_hold_a: assert property (
    RECEIVE_OVERFLOW_FLAG && !OVERFLOW_CLEAR |=> RECEIVE_OVERFLOW_FLAG)
    else $error("overflow lost");
  ovf_cause_a: assert property (
    $rose(RECEIVE_OVERFLOW_FLAG) |-> TRANSFER_DONE || $past(TRANSFER_DONE))
    else $error("overflow without word");
  idle_pins_a: assert property (
    !PORT_ENABLE |-> !SERIAL_DATA_OUT_OE && !SHIFT_CLOCK_OE)
    else $error("pins driven while off");
  master_clock_a: assert property (
    SHIFT_CLOCK_OE |-> CONTROL_REG_ONE[5]) else $error("slave drives clock");
  no_sdo_a: assert property (
    CONTROL_REG_ONE[11] |-> !SERIAL_DATA_OUT_OE) else $error("data out on");
  cover property (TRANSFER_DONE && CONTROL_REG_ONE[10]);
  cover property ($rose(RECEIVE_OVERFLOW_FLAG));
  cover property (TX_BUFFER_FULL_FLAG && !SHIFT_REG_EMPTY);
endmodule
bind sbsp_top sbsp_chk chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
  .CONTROL_REG_ONE(CONTROL_REG_ONE), .CONTROL_REG_TWO(CONTROL_REG_TWO),
  .PORT_ENABLE(PORT_ENABLE),
  .TX_WRITE(TX_WRITE), .TX_READY(TX_READY), .RX_VALID(RX_VALID),
  .OVERFLOW_CLEAR(OVERFLOW_CLEAR),
  .RECEIVE_OVERFLOW_FLAG(RECEIVE_OVERFLOW_FLAG),
  .TX_BUFFER_FULL_FLAG(TX_BUFFER_FULL_FLAG),
  .SHIFT_REG_EMPTY(SHIFT_REG_EMPTY), .TRANSFER_DONE(TRANSFER_DONE),
  .SERIAL_DATA_OUT_OE(SERIAL_DATA_OUT_OE), .SHIFT_CLOCK_OE(SHIFT_CLOCK_OE));

/* sim/sbsp_peer.sv */
// Model of the serial peripheral on the far side of the port
`timescale 1ns/1ps
module sbsp_peer (
  // Bench control
  input wire load,
  input wire [15:0] reply,
  input wire wide,
  // Serial pins
  input wire sck,
  input wire sck_oe,
  input wire sdo,
  output wire sdi,
  // Captured traffic
  output reg [15:0] cap_q
);
  reg [15:0] sh_q;
  wire bit_w = wide ? sh_q[15] : sh_q[7];
  // Rotate so byte bursts replay the upper byte next
  always @(negedge sck or posedge load) begin
    if (load) begin
      sh_q <= reply;
    end else begin
      sh_q <= {sh_q[14:0], sh_q[15]};
    end
  end
  // Capture on the trailing edge, after the port's data has settled
  always @(negedge sck) begin
    cap_q <= {cap_q[14:0], sdo};
  end
  // Released line shows the inverse so stale bits cannot pass
  assign sdi = sck_oe ? bit_w : ~bit_w;
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the buffered serial port
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0] pp;
    logic [2:0] sp;
    logic w;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [7:0] per;
  } sbsp_row_t;
  localparam sbsp_row_t ROWS [0:5] = '{
    {2'h3, 3'h7, 1'h0, 16'h00A5, 16'h003C, 8'h02},
    {2'h2, 3'h7, 1'h1, 16'hC35A, 16'h9F01, 8'h04},
    {2'h2, 3'h6, 1'h0, 16'h0081, 16'h007E, 8'h08},
    {2'h3, 3'h0, 1'h1, 16'h8001, 16'h6BD2, 8'h08},
    {2'h1, 3'h7, 1'h0, 16'h0040, 16'h00C3, 8'h10},
    {2'h0, 3'h7, 1'h0, 16'h00FF, 16'h0001, 8'h40}};
  reg clk, rstn, en, wr, rd, oclr, load;
  reg [15:0] c1, c2, td, rep;
  wire [15:0] rxd, cap;
  wire [2:0] txc, rxc;
  wire rdy, rxv, ovf, tbf, sre, rxe, done, sdo, sdo_oe, sck, sck_oe;
  wire sel_oe, sel_out, sdi;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  sbsp_top uut (.REF_CLK(clk), .RESETN(rstn), .CONTROL_REG_ONE(c1),
    .CONTROL_REG_TWO(c2), .PORT_ENABLE(en), .TX_WRITE(wr), .TX_DATA(td),
    .TX_READY(rdy), .RX_READ(rd), .RX_DATA(rxd), .RX_VALID(rxv),
    .OVERFLOW_CLEAR(oclr), .RECEIVE_OVERFLOW_FLAG(ovf),
    .TX_BUFFER_FULL_FLAG(tbf), .SHIFT_REG_EMPTY(sre), .RX_FIFO_EMPTY(rxe),
    .TX_PENDING_COUNT(txc), .RX_UNREAD_COUNT(rxc), .TRANSFER_DONE(done),
    .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
    .SERIAL_DATA_OUT_OE(sdo_oe), .SHIFT_CLOCK_IN(1'h0),
    .SHIFT_CLOCK_OUT(sck), .SHIFT_CLOCK_OE(sck_oe),
    .SELECT_N_OR_FRAME_PULSE_IN(1'h1), .SELECT_N_OR_FRAME_PULSE_OUT(sel_out),
    .SELECT_N_OR_FRAME_PULSE_OE(sel_oe));
  sbsp_peer peer (.load(load), .reply(rep), .wide(c1[10]),
    .sck(sck & sck_oe), .sck_oe(sck_oe), .sdo(sdo), .sdi(sdi), .cap_q(cap));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic ck(input [15:0] got, input [15:0] exp);
    begin
      n_tests++;
      if (got !== exp) begin
        n_errors++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic give_verdict;
    begin
      if (n_errors == 0 && n_tests > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // Port is switched off while reconfigured, which also flushes the FIFOs
  task automatic setup(input [15:0] a, input [15:0] b, input [15:0] r);
    begin
      @(negedge clk);
      en = 1'h0;
      c1 = a;
      c2 = b;
      rep = r;
      load = 1'h1;
      oclr = 1'h1;
      @(negedge clk);
      load = 1'h0;
      oclr = 1'h0;
      en = 1'h1;
    end
  endtask
  task automatic send(input [15:0] d, output int n);
    begin
      @(negedge clk);
      wr = 1'h1;
      td = d;
      @(negedge clk);
      wr = 1'h0;
      n = 0;
      while (done !== 1'h1 && n < 2000) begin
        @(negedge clk);
        n++;
      end
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int n;
    int k;
    int d;
    logic [15:0] m;
    rstn = 1'h0;
    {en, wr, rd, oclr, load} = 5'h00;
    {c1, c2, td, rep} = 64'h0;
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    ck({10'h000, done, ovf, tbf, sdo_oe, sck_oe, sel_oe}, 16'h0000);
    ck({15'h0000, rxe}, 16'h0001);
    setup(16'h0800, 16'h0000, 16'h0000);
    @(negedge clk);
    ck({14'h0000, sdo_oe, sck_oe}, 16'h0000);
    setup(16'h0820, 16'h0000, 16'h0000);
    @(negedge clk);
    ck({13'h0000, sdo_oe, sck_oe, sel_out}, 16'h0003);
    setup(16'h1020, 16'h8000, 16'h0000);
    @(negedge clk);
    ck({12'h000, sdo_oe, sck_oe, sel_oe, sel_out}, 16'h000A);
    foreach (ROWS[i]) begin
      setup({5'h00, ROWS[i].w, 4'h0, 1'h1, ROWS[i].sp, ROWS[i].pp},
        16'h0000, ROWS[i].rx);
      send(ROWS[i].tx, n);
      k = (ROWS[i].w ? 16 : 8) * ROWS[i].per;
      ck({15'h0000, n >= k && n <= k + 4}, 16'h0001);
      m = ROWS[i].w ? 16'hFFFF : 16'h00FF;
      @(negedge clk);
      ck(rxd, ROWS[i].rx & m);
      ck({11'h000, rxv, sre, rxc}, 16'h0019);
      ck(cap & m, ROWS[i].tx & m);
      rd = 1'h1;
      @(negedge clk);
      rd = 1'h0;
    end
    // Second word arrives unread in single-buffer mode
    setup(16'h003E, 16'h0000, 16'h5AC3);
    send(16'h0011, n);
    send(16'h0022, n);
    repeat (2) @(negedge clk);
    ck({15'h0000, ovf}, 16'h0001);
    ck(rxd, 16'h00C3);
    oclr = 1'h1;
    @(negedge clk);
    oclr = 1'h0;
    ck({15'h0000, ovf}, 16'h0000);
    setup(16'h003E, 16'h0001, 16'hA5A5);
    k = 0;
    @(negedge clk);
    while (rdy === 1'h1 && k < 12) begin
      wr = 1'h1;
      td = k[15:0];
      k++;
      @(negedge clk);
    end
    wr = 1'h0;
    ck({15'h0000, tbf}, 16'h0001);
    ck({12'h000, sre, txc}, 16'h0000);
    ck({15'h0000, k >= 8}, 16'h0001);
    d = 0;
    n = 0;
    while (d < k && n < 3000) begin
      @(negedge clk);
      n++;
      if (done === 1'h1) d++;
    end
    @(negedge clk);
    ck({15'h0000, ovf}, {15'h0000, k > 8});
    ck(cap & 16'h00FF, td & 16'h00FF);
    rd = 1'h1;
    repeat (8) begin
      ck(rxd, 16'h00A5);
      @(negedge clk);
    end
    rd = 1'h0;
    ck({15'h0000, rxe}, 16'h0001);
    give_verdict;
  end
endmodule
